// ===== hdl/atp_timer.sv
// Summary of operation
// RULE1 - 32-bit prescaler feeds 32-bit up-counter, both run only when enabled.
// RULE2 - Source select picks RC oscillator, crystal, bus clock or generic clock.
// RULE3 - Software enables the source clock before setting the timer enable bit.
// RULE4 - Software never changes source select and clock enable in one write.
// RULE5 - Start: write source, poll pending, set enable, poll pending again.
// RULE6 - Stop: clear clock enable with source unchanged, poll pending to zero.
// RULE7 - Change source: disable and wait, select and wait, enable and wait.
// RULE8 - Switch pending sets when clock enable changes, clears when safe again.
// RULE9 - Prescaler increments on every source clock rising edge while enabled.
// RULE10 - Prescaler unreadable, cleared to zero by writing one to prescaler clear.
// RULE11 - Prescaler bit selected by tap select clocks the counter.
// RULE12 - Debug halt freezes prescaler and counter unless run-in-debug and mask set.
// RULE13 - Counting goes on while source runs, independent of the bus clock; here every source is sampled and counted on the bus clock clk.
// RULE14 - Timer can raise a wake request from any sleep mode.
// RULE15 - Periodic, alarm and wrap events; alarm may optionally clear the counter.
// RULE16 - Software programs the interrupt controller before using the request.
// RULE17 - Counter wraps from all ones to zero and sets the wrap flag.
// RULE18 - While sync busy, writes to synced registers are dropped, reads give zero.
// RULE19 - Switch pending also sets after a source select write until taken over.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module atp_timer (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        rcOscIn,
    input  wire logic        xtalOscIn,
    input  wire logic        genClkIn,
    input  wire logic        debugHalt,
    input  wire logic        runInDebug,
    input  wire logic        debugFreezeMask,
    output logic             irq,
    output logic             wakeReq
);

    logic [1:0]              rstPipe;
    logic                    rstSync;
    atp_pkg::atp_state_type  st;
    atp_pkg::atp_state_type  next_st;
    logic                    srcTick;
    logic                    frozen;
    logic                    running;
    logic                    applyNow;
    logic                    cntRise;
    logic                    busAccess;
    logic                    busWrite;
    logic                    syncReg;
    logic [31:0]             readData;
    logic                    readHit;
    logic [atp_pkg::EVT_W-1:0] events;
    logic [atp_pkg::EVT_W-1:0] clrMask;
    logic [31:0]             nextPre;

    // Reset is released through two flip-flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    // Source tick: bus clock counts every cycle, the others on a synced rising edge.
    always_comb begin
        if (st.activeSel == atp_pkg::SRC_PB) begin
            srcTick = 1'b1; // RULE2
        end else if (st.activeSel == atp_pkg::SRC_RC) begin
            srcTick = st.srcStable[0] & ~st.srcLast[0];
        end else if (st.activeSel == atp_pkg::SRC_XTAL) begin
            srcTick = st.srcStable[1] & ~st.srcLast[1];
        end else begin
            srcTick = st.srcStable[2] & ~st.srcLast[2];
        end
    end

    // Debug freeze and run condition.
    assign frozen   = debugHalt & ~(runInDebug & debugFreezeMask); // RULE12
    assign running  = st.activeCen & st.enable & ~frozen;          // RULE1 RULE13
    assign applyNow = st.busy && (st.syncCnt == 4'h1);
    assign nextPre  = 32'(st.prescaler + 32'h1);
    assign cntRise  = ~st.prescaler[st.tap] & nextPre[st.tap];     // RULE11

    // Bus decode; the write lands on the edge where pready is seen high.
    assign busAccess = psel & penable;
    assign busWrite  = busAccess & pwrite & (st.apbState == atp_pkg::ATP_ANSWER);
    assign syncReg   = (paddr == atp_pkg::OFF_CTRL) || (paddr == atp_pkg::OFF_COUNT)
                    || (paddr == atp_pkg::OFF_WAKEEN) || (paddr == atp_pkg::OFF_ALARM)
                    || (paddr == atp_pkg::OFF_PERSEL);

    // Read multiplexer; synchronised registers read zero while busy.
    always_comb begin
        readData = 32'h0;
        readHit  = 1'b1;
        if (paddr == atp_pkg::OFF_CTRL) begin
            readData[atp_pkg::CTRL_EN]     = st.enable;
            readData[atp_pkg::CTRL_CLRALM] = st.clrOnAlarm;
            readData[atp_pkg::CTRL_TAP_LSB +: atp_pkg::TAP_W] = st.tap;
        end else if (paddr == atp_pkg::OFF_COUNT) begin
            readData = st.counter;
        end else if (paddr == atp_pkg::OFF_STATUS) begin
            readData[atp_pkg::EVT_W-1:0]   = st.status;
            readData[atp_pkg::ST_BUSY]     = st.busy;
            readData[atp_pkg::ST_CLOCK_SWITCH_PENDING]  = st.clock_switch_pending;
        end else if (paddr == atp_pkg::OFF_IMASK) begin
            readData[atp_pkg::EVT_W-1:0] = st.intMask;
        end else if (paddr == atp_pkg::OFF_WAKEEN) begin
            readData[atp_pkg::EVT_W-1:0] = st.wakeEn;
        end else if (paddr == atp_pkg::OFF_ALARM) begin
            readData = st.alarm;
        end else if (paddr == atp_pkg::OFF_PERSEL) begin
            readData[atp_pkg::TAP_W-1:0] = st.perTap;
        end else if (paddr == atp_pkg::OFF_CLOCK) begin
            readData[atp_pkg::CLK_CEN] = st.prescaler_clock_enable;
            readData[atp_pkg::CLK_SEL_LSB +: atp_pkg::SEL_W] = st.clock_source_select;
        end else begin
            readHit = 1'b0;
        end
        if (st.busy && syncReg) begin
            readData = 32'h0; // RULE18
        end
    end

    // Next state of the whole block.
    always_comb begin
        next_st = st;
        events  = '0;
        clrMask = '0;

        // Two-flop synchronisers on the oscillator pins, then edge history.
        next_st.srcMeta   = {genClkIn, xtalOscIn, rcOscIn};
        next_st.srcStable = st.srcMeta;
        next_st.srcLast   = st.srcStable;

        // Prescaler, tapped counter, periodic, wrap and alarm events.
        if (running && srcTick) begin
            next_st.prescaler = nextPre; // RULE9
            if (~st.prescaler[st.perTap] & nextPre[st.perTap]) begin
                events[atp_pkg::ST_PER] = 1'b1; // RULE15
            end
            if (cntRise) begin
                if (st.counter == atp_pkg::ALL_ONES) begin
                    next_st.counter = 32'h0; // RULE17
                    events[atp_pkg::ST_WRAP] = 1'b1;
                end else begin
                    next_st.counter = 32'(st.counter + 32'h1);
                end
                if (next_st.counter == st.alarm) begin
                    events[atp_pkg::ST_ALARM] = 1'b1; // RULE15
                    if (st.clrOnAlarm) begin
                        next_st.counter = 32'h0;
                        events[atp_pkg::ST_WRAP] = 1'b1;
                    end
                end
            end
        end

        // Clock switch takeover after a fixed settling delay.
        if (st.clock_switch_pending) begin
            next_st.clkCnt = 4'(st.clkCnt - 4'h1);
            if (st.clkCnt == 4'h1) begin
                next_st.clock_switch_pending   = 1'b0; // RULE8 RULE19
                next_st.activeCen = st.prescaler_clock_enable;
                next_st.activeSel = st.clock_source_select;
                events[atp_pkg::ST_CLKRDY] = 1'b1;
            end
        end

        // Deferred register write reaches the counting logic.
        if (st.busy) begin
            next_st.syncCnt = 4'(st.syncCnt - 4'h1);
        end
        if (applyNow) begin
            next_st.busy = 1'b0;
            events[atp_pkg::ST_READY] = 1'b1;
            if (st.pendAddr == atp_pkg::OFF_CTRL) begin
                next_st.enable     = st.pendData[atp_pkg::CTRL_EN];
                next_st.clrOnAlarm = st.pendData[atp_pkg::CTRL_CLRALM];
                next_st.tap = st.pendData[atp_pkg::CTRL_TAP_LSB +: atp_pkg::TAP_W];
                if (st.pendData[atp_pkg::CTRL_PRESCALER_CLEAR]) begin
                    next_st.prescaler = 32'h0; // RULE10
                end
            end else if (st.pendAddr == atp_pkg::OFF_COUNT) begin
                next_st.counter = st.pendData;
            end else if (st.pendAddr == atp_pkg::OFF_WAKEEN) begin
                next_st.wakeEn = st.pendData[atp_pkg::EVT_W-1:0];
            end else if (st.pendAddr == atp_pkg::OFF_ALARM) begin
                next_st.alarm = st.pendData;
            end else begin
                next_st.perTap = st.pendData[atp_pkg::TAP_W-1:0];
            end
        end

        // Bus answer: data is fixed one edge into the access phase.
        if (st.apbState == atp_pkg::ATP_IDLE) begin
            if (busAccess) begin
                next_st.apbState = atp_pkg::ATP_ANSWER;
                next_st.pready   = 1'b1;
                next_st.pslverr  = ~readHit;
                next_st.prdata   = pwrite ? 32'h0 : readData;
            end
        end else begin
            next_st.apbState = atp_pkg::ATP_IDLE;
            next_st.pready   = 1'b0;
            next_st.pslverr  = 1'b0;
        end

        // Register writes.
        if (busWrite) begin
            if (paddr == atp_pkg::OFF_CLOCK) begin
                if (!st.clock_switch_pending) begin
                    next_st.prescaler_clock_enable   = pwdata[atp_pkg::CLK_CEN];
                    next_st.clock_source_select = pwdata[atp_pkg::CLK_SEL_LSB +: atp_pkg::SEL_W];
                    if ((pwdata[atp_pkg::CLK_CEN] != st.prescaler_clock_enable) || (next_st.clock_source_select != st.clock_source_select)) begin
                        next_st.clock_switch_pending = 1'b1; // RULE8 RULE19
                        next_st.clkCnt  = atp_pkg::SYNC_CYCLES;
                    end
                end
            end else if (paddr == atp_pkg::OFF_STATUS) begin
                clrMask = pwdata[atp_pkg::EVT_W-1:0];
            end else if (paddr == atp_pkg::OFF_IMASK) begin
                next_st.intMask = pwdata[atp_pkg::EVT_W-1:0];
            end else if (syncReg && !st.busy) begin
                next_st.busy     = 1'b1; // RULE18
                next_st.syncCnt  = atp_pkg::SYNC_CYCLES;
                next_st.pendAddr = paddr;
                next_st.pendData = pwdata;
            end
        end

        // Sticky status: a new event wins over a clear in the same cycle.
        next_st.status  = (st.status & ~clrMask) | events;
        next_st.irq     = |(next_st.status & next_st.intMask);
        next_st.wakeReq = |(next_st.status & next_st.wakeEn); // RULE14
    end

    // State register.
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            st          <= '0;
            st.apbState <= atp_pkg::ATP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign prdata  = st.prdata;
    assign irq     = st.irq;
    assign wakeReq = st.wakeReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync);

    AST_CLK_SET: assert property (busWrite && paddr == atp_pkg::OFF_CLOCK && !st.clock_switch_pending // RULE8
        && pwdata[atp_pkg::CLK_CEN] != st.prescaler_clock_enable |=> st.clock_switch_pending)
        else $error("Clock switch pending did not set on enable change.");
    AST_CLK_DONE: assert property ($rose(st.clock_switch_pending) |-> ##[1:15] !st.clock_switch_pending) // RULE19
        else $error("Clock switch pending never cleared.");
    AST_HOLD: assert property (!running && !applyNow |=> $stable(st.prescaler)) // RULE1
        else $error("Prescaler moved while stopped.");
    AST_PRE_INC: assert property (running && srcTick && !applyNow // RULE9
        |=> st.prescaler == 32'($past(st.prescaler) + 32'h1))
        else $error("Prescaler missed a source edge.");
    AST_FREEZE: assert property (frozen && !applyNow |=> $stable(st.counter)) // RULE12
        else $error("Counter moved during debug freeze.");
    AST_WRAP: assert property (running && srcTick && cntRise && !applyNow // RULE17
        && st.counter == atp_pkg::ALL_ONES |=> st.counter == 32'h0 && st.status[0])
        else $error("Counter wrap not flagged.");
    AST_TAP: assert property (!cntRise && !applyNow |=> $stable(st.counter)) // RULE11
        else $error("Counter stepped without a tap edge.");
    AST_BUSY_RD: assert property (st.apbState == atp_pkg::ATP_IDLE && busAccess && !pwrite // RULE18
        && syncReg && st.busy |=> prdata == 32'h0)
        else $error("Busy read returned nonzero data.");
    AST_PRESCALER_CLEAR: assert property (applyNow && st.pendAddr == atp_pkg::OFF_CTRL // RULE10
        && st.pendData[atp_pkg::CTRL_PRESCALER_CLEAR] |=> st.prescaler == 32'h0)
        else $error("Prescaler clear had no effect.");
    AST_IRQ: assert property ((st.status & st.intMask) != '0 // RULE15
        |-> irq)
        else $error("Unmasked event did not raise the interrupt.");
    AST_WAKE: assert property ((st.status & st.wakeEn) != '0 |-> wakeReq) // RULE14
        else $error("Wake request missing.");
    AST_RUN: assert property (st.activeSel == atp_pkg::SRC_PB && running && !applyNow // RULE13
        |=> st.prescaler != $past(st.prescaler))
        else $error("Prescaler stalled on bus clock source.");

endmodule : atp_timer
`default_nettype wire

// ===== hdl/atp_pkg.sv
package atp_pkg;

    // Bus geometry.
    localparam int          DATA_W   = 32;
    localparam int          ADDR_W   = 8;
    localparam int          EVT_W    = 5;
    localparam int          TAP_W    = 5;
    localparam int          SEL_W    = 2;
    localparam int          CNT_W    = 4;

    // Register offsets, byte addresses.
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_COUNT  = 8'h04;
    localparam logic [7:0]  OFF_STATUS = 8'h08;
    localparam logic [7:0]  OFF_IMASK  = 8'h0c;
    localparam logic [7:0]  OFF_WAKEEN = 8'h10;
    localparam logic [7:0]  OFF_ALARM  = 8'h14;
    localparam logic [7:0]  OFF_PERSEL = 8'h18;
    localparam logic [7:0]  OFF_CLOCK  = 8'h1c;

    // Control register fields.
    localparam int          CTRL_EN       = 0;
    localparam int          CTRL_PRESCALER_CLEAR     = 1;
    localparam int          CTRL_CLRALM   = 2;
    localparam int          CTRL_TAP_LSB  = 8;

    // Status and event bit positions; bits 0 to 4 are shared by status, mask and wake enable, busy and pending are status only.
    localparam int          ST_WRAP    = 0;
    localparam int          ST_PER     = 1;
    localparam int          ST_ALARM   = 2;
    localparam int          ST_CLKRDY  = 3;
    localparam int          ST_READY   = 4;
    localparam int          ST_BUSY    = 8;
    localparam int          ST_CLOCK_SWITCH_PENDING = 9;

    // Clock register fields and source codes.
    localparam int          CLK_CEN     = 0;
    localparam int          CLK_SEL_LSB = 8;
    localparam logic [1:0]  SRC_RC   = 2'h0;
    localparam logic [1:0]  SRC_XTAL = 2'h1;
    localparam logic [1:0]  SRC_PB   = 2'h2;
    localparam logic [1:0]  SRC_GEN  = 2'h3;

    // Cycles that a write needs to reach the counting logic.
    localparam logic [3:0]  SYNC_CYCLES = 4'h3;
    localparam logic [31:0] ALL_ONES    = 32'hffffffff;

    // Bus answer state machine.
    typedef enum logic [1:0] {
        ATP_IDLE   = 2'b01,
        ATP_ANSWER = 2'b10
    } atp_apb_type;

    // Whole state of the timer front end.
    typedef struct packed {
        atp_apb_type        apbState;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               irq;
        logic               wakeReq;
        logic [2:0]         srcMeta;
        logic [2:0]         srcStable;
        logic [2:0]         srcLast;
        logic               enable;
        logic               clrOnAlarm;
        logic [TAP_W-1:0]   tap;
        logic [TAP_W-1:0]   perTap;
        logic [31:0]        alarm;
        logic [31:0]        counter;
        logic [31:0]        prescaler;
        logic [EVT_W-1:0]   status;
        logic [EVT_W-1:0]   intMask;
        logic [EVT_W-1:0]   wakeEn;
        logic               prescaler_clock_enable;
        logic [SEL_W-1:0]   clock_source_select;
        logic               activeCen;
        logic [SEL_W-1:0]   activeSel;
        logic               clock_switch_pending;
        logic [CNT_W-1:0]   clkCnt;
        logic               busy;
        logic [CNT_W-1:0]   syncCnt;
        logic [7:0]         pendAddr;
        logic [31:0]        pendData;
    } atp_state_type;

endpackage : atp_pkg

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rcOscIn = 1'b0;
    logic        xtalOscIn = 1'b0;
    logic        genClkIn = 1'b0;
    logic        debugHalt;
    logic        runInDebug;
    logic        debugFreezeMask;
    logic        irq;
    logic        wakeReq;
    logic [3:0]  oscCnt = 4'h0;
    logic [31:0] rd;
    logic [31:0] rv;
    logic [31:0] d;
    logic [31:0] qData[$];
    logic [31:0] qMask[$];
    logic        qErr[$];
    int          errors;
    int          n_tests;
    integer      seed;

    atp_timer dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .rcOscIn(rcOscIn), .xtalOscIn(xtalOscIn), .genClkIn(genClkIn), .debugHalt(debugHalt),
        .runInDebug(runInDebug), .debugFreezeMask(debugFreezeMask), .irq(irq), .wakeReq(wakeReq));

    // Free-running bus clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Slow source clocks on the oscillator pins, so none of them sits idle.
    always @(posedge clk) begin
        oscCnt <= oscCnt + 4'h1;
        rcOscIn <= oscCnt[1];
        xtalOscIn <= oscCnt[3];
        genClkIn <= oscCnt[0];
    end

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // Compares one value against its expectation and counts the outcome.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; the expected answer is queued for the monitor first.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat,
                       input logic [31:0] m, input logic [31:0] e, input logic err);
        int k;
        qData.push_back(e & m);
        qMask.push_back(m);
        qErr.push_back(err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            stop_test();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls one status bit until it reads zero, within a bounded number of reads.
    task automatic poll(input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, atp_pkg::OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
            k++;
        end while (rd[b] !== 1'b0 && k < 30);
        if (k >= 30) begin
            errors++;
            stop_test();
        end
    endtask : poll

    // Counter progress across a gap of n cycles.
    task automatic delta(input int n, output logic [31:0] dl);
        logic [31:0] c0;
        apb(1'b0, atp_pkg::OFF_COUNT, 32'h0, 32'h0, 32'h0, 1'b0);
        c0 = rd;
        repeat (n) @(posedge clk);
        apb(1'b0, atp_pkg::OFF_COUNT, 32'h0, 32'h0, 32'h0, 1'b0);
        dl = rd - c0;
    endtask : delta

    // Takes the oldest queued expectation whenever an answer appears.
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            if (qData.size() == 0) begin
                check("unexpected answer", 32'h1, 32'h0);
            end else begin
                check("read data", prdata & qMask[0], qData[0]);
                check("slave error", {31'h0, pslverr}, {31'h0, qErr[0]});
                void'(qData.pop_front());
                void'(qMask.pop_front());
                void'(qErr.pop_front());
            end
        end
    end

    // Bounds the whole run.
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        stop_test();
    end

    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {debugHalt, runInDebug, debugFreezeMask} = 3'b000;
        rst_b = 1'b0;
        errors = 0;
        n_tests = 0;
        seed = 32'he14f080c;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        check("wake", {31'h0, wakeReq}, 32'h0);
        apb(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, 8'h44, 32'h5, 32'hffffffff, 32'h0, 1'b1);
        for (int s = 0; s < 4; s++) begin
            // Sources 1, 0, 3, 2 in turn: every write changes the source, never the enable.
            apb(1'b1, atp_pkg::OFF_CLOCK, ((s * 3 + 1) & 3) << 8, 32'hffffffff, 32'h0, 1'b0);
            apb(1'b0, atp_pkg::OFF_STATUS, 32'h0, 32'h200, 32'h200, 1'b0);
            poll(9);
        end
        apb(1'b1, atp_pkg::OFF_CLOCK, 32'h201, 32'hffffffff, 32'h0, 1'b0);
        apb(1'b0, atp_pkg::OFF_STATUS, 32'h0, 32'h200, 32'h200, 1'b0);
        poll(9);
        check("clock ready", {31'h0, rd[3]}, 32'h1);
        apb(1'b0, atp_pkg::OFF_CLOCK, 32'h0, 32'h301, 32'h201, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rv = $random(seed);
            apb(1'b1, atp_pkg::OFF_IMASK, rv, 32'hffffffff, 32'h0, 1'b0);
            apb(1'b0, atp_pkg::OFF_IMASK, 32'h0, 32'hffffffff, rv & 32'h1f, 1'b0);
        end
        apb(1'b1, atp_pkg::OFF_IMASK, 32'h0, 32'hffffffff, 32'h0, 1'b0);
        apb(1'b1, atp_pkg::OFF_CTRL, 32'h201, 32'hffffffff, 32'h0, 1'b0);
        apb(1'b0, atp_pkg::OFF_CTRL, 32'h0, 32'hffffffff, 32'h0, 1'b0);
        poll(8);
        apb(1'b0, atp_pkg::OFF_CTRL, 32'h0, 32'h1f01, 32'h201, 1'b0);
        delta(80, d);
        check("tap rate", {31'h0, d >= 32'd9 && d <= 32'd12}, 32'h1);
        debugHalt <= 1'b1;
        repeat (6) @(posedge clk);
        delta(40, d);
        check("debug frozen", d, 32'h0);
        runInDebug <= 1'b1;
        debugFreezeMask <= 1'b1;
        repeat (6) @(posedge clk);
        delta(40, d);
        check("debug running", {31'h0, d >= 32'd4}, 32'h1);
        {debugHalt, runInDebug, debugFreezeMask} <= 3'b000;
        apb(1'b1, atp_pkg::OFF_CTRL, 32'h003, 32'hffffffff, 32'h0, 1'b0);
        poll(8);
        apb(1'b1, atp_pkg::OFF_WAKEEN, 32'h1, 32'hffffffff, 32'h0, 1'b0);
        poll(8);
        apb(1'b1, atp_pkg::OFF_COUNT, 32'hfffffff0, 32'hffffffff, 32'h0, 1'b0);
        poll(8);
        repeat (60) @(posedge clk);
        apb(1'b0, atp_pkg::OFF_STATUS, 32'h0, 32'h3, 32'h3, 1'b0);
        apb(1'b0, atp_pkg::OFF_COUNT, 32'h0, 32'hffffff00, 32'h0, 1'b0);
        check("masked irq", {31'h0, irq}, 32'h0);
        check("wake", {31'h0, wakeReq}, 32'h1);
        apb(1'b1, atp_pkg::OFF_IMASK, 32'h1, 32'hffffffff, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, atp_pkg::OFF_STATUS, 32'h1, 32'hffffffff, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        check("wake cleared", {31'h0, wakeReq}, 32'h0);
        apb(1'b1, atp_pkg::OFF_CLOCK, 32'h200, 32'hffffffff, 32'h0, 1'b0);
        poll(9);
        repeat (6) @(posedge clk);
        delta(40, d);
        check("stopped", d, 32'h0);
        // Source change while stopped: select the RC oscillator, then enable again.
        apb(1'b1, atp_pkg::OFF_CLOCK, 32'h000, 32'hffffffff, 32'h0, 1'b0);
        poll(9);
        apb(1'b1, atp_pkg::OFF_CLOCK, 32'h001, 32'hffffffff, 32'h0, 1'b0);
        poll(9);
        repeat (6) @(posedge clk);
        delta(40, d);
        check("rc source rate", {31'h0, d >= 32'd4 && d <= 32'd7}, 32'h1);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
